// ===== design/pcg_pkg.sv
package pcg_pkg;
  // Shift register geometry and code period.
  localparam int unsigned LFSR_W          = 10;
  localparam logic [9:0]  LFSR_INIT       = 10'h3ff;
  localparam int unsigned CODE_LEN        = 1023;
  localparam logic [9:0]  CODE_LAST       = 10'h3fe;
  // Reference register feedback taps (x^10 + x^3 + 1), stage numbers 1..10.
  localparam int unsigned REF_TAP_A       = 3;
  localparam int unsigned REF_TAP_B       = 10;
  // Code numbers.
  localparam int unsigned CODE_NUM_W      = 6;
  localparam logic [5:0]  CODE_NUM_MIN    = 6'h01;
  localparam logic [5:0]  CODE_NUM_SAT_MAX = 6'h20;
  localparam logic [5:0]  CODE_NUM_MAX    = 6'h25;
  // Data bit spans this many code periods.
  localparam logic [4:0]  EPOCHS_PER_BIT  = 5'h14;
  localparam logic [4:0]  EPOCH_LAST     = 5'h13;
  // Clocking: system clock, frequency standard, chip rate.
  localparam real         MCLK_MHZ        = 125.0;
  localparam real         STD_MHZ         = 10.23;
  localparam real         CHIP_MHZ        = 1.023;
  localparam int unsigned STD_PER_CHIP    = int'(STD_MHZ / CHIP_MHZ);
  localparam logic [3:0]  STD_DIV_LAST    = 4'(STD_PER_CHIP - 1);

  typedef enum logic [2:0] {
    PCG_IDLE     = 3'b001,
    PCG_RUN      = 3'b010,
    PCG_FALLBACK = 3'b100
  } pcg_state_t;
endpackage

// ===== design/pcg_sync2.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a level coming from outside the clock domain.
module pcg_sync2 (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic din,
  output logic      dout
);
  logic meta_r;

  // The first flop is read only by the second one.
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule

// ===== design/pcg_gen.sv
`timescale 1ns/1ps
// Behaviour
// RULE_01 - Two ten-stage LFSRs with given polynomials.
// RULE_02 - Both registers start at all ones.
// RULE_03 - Advance once per chip, 1.023 MHz.
// RULE_04 - Delay made by XOR of two stages.
// RULE_05 - Chip is reference XOR delayed sequence.
// RULE_06 - Stage pair chosen from code table.
// RULE_07 - Tap pairs give 5 to 950 delays.
// RULE_08 - Thirty-six phases from one generator.
// RULE_09 - Data bit XORed onto chip stream.
// RULE_10 - Receiver regenerates code to strip data.
// RULE_11 - First ten chips match reference values.
// RULE_12 - Codes 34 and 37 share taps.
// RULE_13 - Codes 33 to 37 reserved, non-satellite.
// RULE_14 - Chip clock divided from 10.23 MHz standard.
// RULE_15 - Chip and data timing share one source.
// RULE_16 - Malfunction switches to fallback code.
// RULE_17 - Tenth stage output; restart each epoch.
// RULE_18 - Data bit spans twenty code periods.
module pcg_gen (
  input  wire logic                        mclk,
  input  wire logic                        reset,
  input  wire logic                        std_tick,
  input  wire logic                        enable,
  input  wire logic [pcg_pkg::CODE_NUM_W-1:0] code_num,
  input  wire logic                        nav_data,
  input  wire logic                        malfunction,
  output logic                             chip_out,
  output logic                             gold_chip_seq,
  output logic                             chip_strobe,
  output logic                             epoch_strobe,
  output logic                             data_req,
  output logic                             code_valid,
  output logic                             fallback_active
);
  import pcg_pkg::*;

  pcg_state_t       state_r;
  pcg_state_t       state_nxt;
  logic             tick_s;
  logic             tick_d_r;
  logic             tick_rise;
  logic [3:0]       div_r;
  logic             chip_en;
  logic [9:0]       reference_lfsr;
  logic [9:0]       selectable_lfsr;
  logic [9:0]       fallback_lfsr;
  logic [9:0]       chip_cnt_r;
  logic [4:0]       epoch_cnt_r;
  logic             data_bit_r;
  logic             fault_s;
  logic             fault_r;
  logic [3:0]       tap_a;
  logic [3:0]       tap_b;
  logic             delayed_selectable_seq;
  logic             gold_now;
  logic             code_ok;
  logic             epoch_end;
  logic             bit_end;

  // The frequency standard tick and malfunction flag come from outside.
  pcg_sync2 u_tick_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   (std_tick),
    .dout  (tick_s)
  );
  pcg_sync2 u_fault_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   (malfunction),
    .dout  (fault_s)
  );

  assign tick_rise = tick_s & ~tick_d_r;

  // Tap table by code number; stage numbers are 1..10.
  always_comb begin
    tap_a = 4'h0;
    tap_b = 4'h0;
    unique case (code_num) // RULE_06 RULE_07 RULE_08
      6'h01: begin tap_a = 4'h2; tap_b = 4'h6; end
      6'h02: begin tap_a = 4'h3; tap_b = 4'h7; end
      6'h03: begin tap_a = 4'h4; tap_b = 4'h8; end
      6'h04: begin tap_a = 4'h5; tap_b = 4'h9; end
      6'h05: begin tap_a = 4'h1; tap_b = 4'h9; end
      6'h06: begin tap_a = 4'h2; tap_b = 4'ha; end
      6'h07: begin tap_a = 4'h1; tap_b = 4'h8; end
      6'h08: begin tap_a = 4'h2; tap_b = 4'h9; end
      6'h09: begin tap_a = 4'h3; tap_b = 4'ha; end
      6'h0a: begin tap_a = 4'h2; tap_b = 4'h3; end
      6'h0b: begin tap_a = 4'h3; tap_b = 4'h4; end
      6'h0c: begin tap_a = 4'h5; tap_b = 4'h6; end
      6'h0d: begin tap_a = 4'h6; tap_b = 4'h7; end
      6'h0e: begin tap_a = 4'h7; tap_b = 4'h8; end
      6'h0f: begin tap_a = 4'h8; tap_b = 4'h9; end
      6'h10: begin tap_a = 4'h9; tap_b = 4'ha; end
      6'h11: begin tap_a = 4'h1; tap_b = 4'h4; end
      6'h12: begin tap_a = 4'h2; tap_b = 4'h5; end
      6'h13: begin tap_a = 4'h3; tap_b = 4'h6; end
      6'h14: begin tap_a = 4'h4; tap_b = 4'h7; end
      6'h15: begin tap_a = 4'h5; tap_b = 4'h8; end
      6'h16: begin tap_a = 4'h6; tap_b = 4'h9; end
      6'h17: begin tap_a = 4'h1; tap_b = 4'h3; end
      6'h18: begin tap_a = 4'h4; tap_b = 4'h6; end
      6'h19: begin tap_a = 4'h5; tap_b = 4'h7; end
      6'h1a: begin tap_a = 4'h6; tap_b = 4'h8; end
      6'h1b: begin tap_a = 4'h7; tap_b = 4'h9; end
      6'h1c: begin tap_a = 4'h8; tap_b = 4'ha; end
      6'h1d: begin tap_a = 4'h1; tap_b = 4'h6; end
      6'h1e: begin tap_a = 4'h2; tap_b = 4'h7; end
      6'h1f: begin tap_a = 4'h3; tap_b = 4'h8; end
      6'h20: begin tap_a = 4'h4; tap_b = 4'h9; end
      // Reserved non-satellite codes; 34 and 37 share one pair.
      6'h21: begin tap_a = 4'h5; tap_b = 4'ha; end // RULE_13
      6'h22: begin tap_a = 4'h4; tap_b = 4'ha; end // RULE_12
      6'h23: begin tap_a = 4'h1; tap_b = 4'h7; end
      6'h24: begin tap_a = 4'h2; tap_b = 4'h8; end
      6'h25: begin tap_a = 4'h4; tap_b = 4'ha; end // RULE_12
      default: begin tap_a = 4'h0; tap_b = 4'h0; end
    endcase
  end

  // Codes outside 1..37 have no tap pair, so the generator will not start.
  assign code_ok = (code_num >= CODE_NUM_MIN) && (code_num <= CODE_NUM_MAX);

  // Stage k lives at bit k-1; the out-of-range guard keeps the index legal.
  assign delayed_selectable_seq = (tap_a == 4'h0) ? 1'b0 :
    selectable_lfsr[tap_a - 4'h1] ^ selectable_lfsr[tap_b - 4'h1]; // RULE_04
  assign gold_now  = reference_lfsr[REF_TAP_B-1] ^ delayed_selectable_seq; // RULE_05 RULE_17
  assign epoch_end = chip_en && (chip_cnt_r == CODE_LAST);
  assign bit_end   = epoch_end && (epoch_cnt_r == EPOCH_LAST);

  // Run control; a malfunction latches the fallback until reset.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PCG_IDLE:     if (enable && code_ok) state_nxt = PCG_RUN;
      PCG_RUN: begin
        if (fault_r) state_nxt = PCG_FALLBACK; // RULE_16
        else if (!enable) state_nxt = PCG_IDLE;
      end
      PCG_FALLBACK: state_nxt = PCG_FALLBACK;
      default:      state_nxt = PCG_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) state_r <= PCG_IDLE;
    else       state_r <= state_nxt;
  end

  // Fault flag is sticky; only reset clears it.
  always_ff @(posedge mclk) begin
    if (reset)        fault_r <= 1'b0;
    else if (fault_s) fault_r <= 1'b1;
  end

  // Chip clock is one in ten standard ticks, all from the same source.
  always_ff @(posedge mclk) begin
    if (reset) begin
      tick_d_r <= 1'b0;
      div_r    <= 4'h0;
      chip_en  <= 1'b0;
    end else begin
      tick_d_r <= tick_s;
      chip_en  <= 1'b0;
      if (tick_rise && state_r != PCG_IDLE) begin // RULE_14 RULE_15
        if (div_r == STD_DIV_LAST) begin
          div_r   <= 4'h0;
          chip_en <= 1'b1; // RULE_03
        end else begin
          div_r <= div_r + 4'h1;
        end
      end else if (state_r == PCG_IDLE) begin
        div_r <= 4'h0;
      end
    end
  end

  // Both registers shift toward stage 10; input is the feedback sum.
  always_ff @(posedge mclk) begin
    if (reset || state_r == PCG_IDLE || epoch_end) begin
      reference_lfsr  <= LFSR_INIT; // RULE_02 RULE_17
      selectable_lfsr <= LFSR_INIT;
    end else if (chip_en) begin
      reference_lfsr  <= {reference_lfsr[8:0],
                          reference_lfsr[REF_TAP_A-1] ^ reference_lfsr[REF_TAP_B-1]}; // RULE_01
      selectable_lfsr <= {selectable_lfsr[8:0],
                          selectable_lfsr[1] ^ selectable_lfsr[2] ^ selectable_lfsr[5] ^
                          selectable_lfsr[7] ^ selectable_lfsr[8] ^ selectable_lfsr[9]}; // RULE_01
    end
  end

  // Fallback sequence: a plain maximal-length register, never a valid code.
  always_ff @(posedge mclk) begin
    if (reset) fallback_lfsr <= LFSR_INIT;
    else if (chip_en) fallback_lfsr <= {fallback_lfsr[8:0], fallback_lfsr[6] ^ fallback_lfsr[9]}; // RULE_16
  end

  // Chip and epoch counters; data bits change only at bit boundaries.
  always_ff @(posedge mclk) begin
    if (reset || state_r == PCG_IDLE) begin
      chip_cnt_r  <= 10'h000;
      epoch_cnt_r <= 5'h00;
      data_bit_r  <= 1'b0;
    end else if (chip_en) begin
      chip_cnt_r <= epoch_end ? 10'h000 : chip_cnt_r + 10'h001;
      if (epoch_end) epoch_cnt_r <= bit_end ? 5'h00 : epoch_cnt_r + 5'h01; // RULE_18
      if (bit_end) data_bit_r <= nav_data; // RULE_18
    end
  end

  // Registered outputs, sampled at each chip boundary.
  always_ff @(posedge mclk) begin
    if (reset) begin
      gold_chip_seq <= 1'b0;
      chip_out      <= 1'b0;
    end else if (chip_en) begin
      gold_chip_seq <= gold_now; // RULE_11
      chip_out      <= (state_r == PCG_FALLBACK) ? fallback_lfsr[9] : (gold_now ^ data_bit_r); // RULE_09 RULE_10
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      chip_strobe  <= 1'b0;
      epoch_strobe <= 1'b0;
      data_req     <= 1'b0;
    end else begin
      chip_strobe  <= chip_en;
      epoch_strobe <= epoch_end;
      data_req     <= bit_end;
    end
  end

  assign code_valid      = (state_r == PCG_RUN) && (code_num <= CODE_NUM_SAT_MAX); // RULE_13
  assign fallback_active = (state_r == PCG_FALLBACK);

  // Checks.
  sequence s_epoch;
    chip_en && chip_cnt_r == CODE_LAST;
  endsequence

  a_lfsr_restart: assert property (@(posedge mclk) disable iff (reset) // RULE_17
    s_epoch |=> (reference_lfsr == LFSR_INIT && selectable_lfsr == LFSR_INIT))
    else $error("registers not reloaded at epoch");
  a_chip_count_wrap: assert property (@(posedge mclk) disable iff (reset) // RULE_03
    (chip_en && chip_cnt_r == CODE_LAST && state_r != PCG_IDLE) |=> chip_cnt_r == 10'h000)
    else $error("chip counter did not wrap at 1023");
  a_chip_spacing: assert property (@(posedge mclk) disable iff (reset) // RULE_14
    chip_en |=> !chip_en [*8])
    else $error("chip enables too close");
  a_fallback_sticky: assert property (@(posedge mclk) disable iff (reset) // RULE_16
    fallback_active |=> fallback_active)
    else $error("fallback left without reset");
  a_fault_enter: assert property (@(posedge mclk) disable iff (reset) // RULE_16
    (fault_r && state_r == PCG_RUN) |=> fallback_active)
    else $error("fault did not force fallback");
  a_data_steady: assert property (@(posedge mclk) disable iff (reset) // RULE_18
    (chip_en && !bit_end) |=> $stable(data_bit_r))
    else $error("data bit changed off a bit boundary");
  a_chip_mix: assert property (@(posedge mclk) disable iff (reset) // RULE_09
    (chip_en && state_r == PCG_RUN) |=> chip_out == (gold_chip_seq ^ $past(data_bit_r)))
    else $error("chip output is not code xor data");
  a_shared_taps: assert property (@(posedge mclk) disable iff (reset) // RULE_12
    (code_num == 6'h25) |-> (tap_a == 4'h4 && tap_b == 4'ha))
    else $error("code 37 taps differ from code 34");
  a_reserved_flag: assert property (@(posedge mclk) disable iff (reset) // RULE_13
    (code_num > CODE_NUM_SAT_MAX) |-> !code_valid)
    else $error("reserved code flagged as satellite code");
endmodule

// ===== dv/pcg_rx_model.sv
`timescale 1ns/1ps
// Receiver side: regenerates the spreading code locally and strips it from the composite chips.
module pcg_rx_model (
  input  wire logic       mclk,
  input  wire logic       align,
  input  wire logic       chip_strobe,
  input  wire logic       chip_out,
  input  wire logic [3:0] tap_a,
  input  wire logic [3:0] tap_b,
  output logic            data_bit
);
  logic [9:0] ref_r;
  logic [9:0] sel_r;
  logic [9:0] cnt_r;
  // Align restarts from all ones; each chip advances both registers once.
  always @(posedge mclk) begin
    if (align) begin
      ref_r <= 10'h3ff;
      sel_r <= 10'h3ff;
      cnt_r <= 10'h000;
      data_bit <= 1'b0;
    end else if (chip_strobe) begin
      data_bit <= chip_out ^ ref_r[9] ^ sel_r[tap_a-1] ^ sel_r[tap_b-1];
      ref_r <= {ref_r[8:0], ref_r[2] ^ ref_r[9]};
      sel_r <= {sel_r[8:0], sel_r[1] ^ sel_r[2] ^ sel_r[5] ^ sel_r[7] ^ sel_r[8] ^ sel_r[9]};
      cnt_r <= (cnt_r == 10'h3fe) ? 10'h000 : cnt_r + 10'h001;
      if (cnt_r == 10'h3fe) begin
        ref_r <= 10'h3ff;
        sel_r <= 10'h3ff;
      end
    end
  end
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pcg_pkg::*;
  logic                  mclk = 1'b0;
  logic                  reset = 1'b1;
  logic                  std_tick = 1'b0;
  logic                  tick_ph = 1'b0;
  logic                  enable = 1'b0;
  logic [CODE_NUM_W-1:0] code_num = 6'h00;
  logic                  nav_data = 1'b0;
  logic                  malfunction = 1'b0;
  logic                  align = 1'b0;
  logic [3:0]            tap_a = 4'h1;
  logic [3:0]            tap_b = 4'h2;
  logic                  chip_out, gold_chip_seq, chip_strobe, epoch_strobe, data_req, code_valid, fallback_active;
  logic                  rx_bit;
  logic [1:0]            e;
  logic [9:0]            hist, h34;
  logic [15:0]           rnd = 16'hd255;
  logic [1:0]            exp_q[$];
  int                    err_count = 0, checks_done = 0, strobes = 0, cyc = 0, last_s = 0, fb_diff = 0, c, s0, i;
  // Stage pair per code number, upper nibble first stage, stage 10 written as a.
  logic [7:0] taps [1:37] = '{8'h26, 8'h37, 8'h48, 8'h59, 8'h19, 8'h2a, 8'h18, 8'h29, 8'h3a, 8'h23, 8'h34, 8'h56,
    8'h67, 8'h78, 8'h89, 8'h9a, 8'h14, 8'h25, 8'h36, 8'h47, 8'h58, 8'h69, 8'h13, 8'h46, 8'h57, 8'h68, 8'h79,
    8'h8a, 8'h16, 8'h27, 8'h38, 8'h49, 8'h5a, 8'h4a, 8'h17, 8'h28, 8'h4a};
  // First ten chips per code number, first chip in the top bit, kept apart from the polynomial model.
  logic [9:0] heads [1:37] = '{10'h320, 10'h390, 10'h3c8, 10'h3e4, 10'h25b, 10'h32d, 10'h259, 10'h32c, 10'h396,
    10'h344, 10'h3a2, 10'h3e8, 10'h3f4, 10'h3fa, 10'h3fd, 10'h3fe, 10'h26e, 10'h337, 10'h39b, 10'h3cd, 10'h3e6,
    10'h3f3, 10'h233, 10'h3c6, 10'h3e3, 10'h3f1, 10'h3f8, 10'h3fc, 10'h257, 10'h32b, 10'h395, 10'h3ca, 10'h3e5,
    10'h3cb, 10'h25c, 10'h32e, 10'h3cb};

  pcg_gen dut (.mclk(mclk), .reset(reset), .std_tick(std_tick), .enable(enable), .code_num(code_num),
    .nav_data(nav_data), .malfunction(malfunction), .chip_out(chip_out), .gold_chip_seq(gold_chip_seq),
    .chip_strobe(chip_strobe), .epoch_strobe(epoch_strobe), .data_req(data_req), .code_valid(code_valid),
    .fallback_active(fallback_active));
  pcg_rx_model rx (.mclk(mclk), .align(align), .chip_strobe(chip_strobe), .chip_out(chip_out),
    .tap_a(tap_a), .tap_b(tap_b), .data_bit(rx_bit));

  always #4 mclk = ~mclk;

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Standard tick with 2 cycles high and 2 low, so a chip comes every 40 cycles, to keep the run short.
  always @(negedge mclk) begin
    tick_ph <= ~tick_ph;
    if (tick_ph) begin
      std_tick <= ~std_tick;
    end
    rnd <= lfsr_next(rnd);
    nav_data <= rnd[0]; // Never sampled: no data bit boundary is reached in these runs.
  end

  task automatic chk(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [9:0] exp, input logic [9:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Expected chips straight from the two polynomials, run on across epochs without reload, as both repeat every 1023 steps.
  task automatic push_code(input int code, input int n);
    logic [9:0] g1, g2;
    logic [3:0] a, b;
    g1 = 10'h3ff;
    g2 = 10'h3ff;
    a = taps[code][7:4];
    b = taps[code][3:0];
    for (int k = 0; k < n; k++) begin
      exp_q.push_back({k % 1023 == 1022, g1[9] ^ g2[a-1] ^ g2[b-1]});
      g1 = {g1[8:0], g1[2] ^ g1[9]};
      g2 = {g2[8:0], g2[1] ^ g2[2] ^ g2[5] ^ g2[7] ^ g2[8] ^ g2[9]};
    end
  endtask

  task automatic run_code(input int code, input int n);
    push_code(code, n);
    tap_a = taps[code][7:4];
    tap_b = taps[code][3:0];
    code_num = 6'(code);
    enable = 1'b1;
    align = 1'b1;
    last_s = 0;
    @(negedge mclk);
    align = 1'b0;
    repeat (2) @(negedge mclk);
    chk("code_valid", code <= 32, code_valid);
    for (i = 0; i < n * 60 && exp_q.size() > 0; i++) @(negedge mclk);
    chk("chips_drained", 1'b1, exp_q.size() == 0);
    enable = 1'b0;
    exp_q.delete();
    repeat (4) @(negedge mclk);
  endtask

  // Watches each chip as it appears and compares it with the oldest note.
  // It looks at the falling edge, so the registered outputs have settled and no edge race is possible.
  always @(negedge mclk) begin
    cyc++;
    if (chip_strobe === 1'b1) begin
      strobes++;
      hist = {hist[8:0], chip_out};
      if (fallback_active === 1'b1 && chip_out !== gold_chip_seq) fb_diff++;
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        chk("chip_out", e[0], chip_out);
        chk("gold_chip_seq", e[0], gold_chip_seq);
        chk("epoch_strobe", e[1], epoch_strobe);
        chk("rx_data", 1'b0, rx_bit);
        chk("data_req", 1'b0, data_req);
        if (last_s > 0) chk("chip_gap", 1'b1, cyc - last_s == 40);
        last_s = cyc;
      end
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    err_count++;
    $display("BAD watchdog expected finish seen hang");
    close_out();
  end

  initial begin
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    for (c = 1; c <= 37; c++) begin
      run_code(c, 10);
      chk_word("code_head", heads[c], hist);
      if (c == 34) h34 = hist;
      if (c == 37) chk_word("code37_head", h34, hist);
    end
    $display("test tap table done");
    foreach (taps[j]) begin
      if (j > 3) break;
      s0 = strobes;
      code_num = (j == 1) ? 6'h00 : (j == 2) ? 6'h26 : 6'(38 + rnd[4:0] % 26);
      enable = 1'b1;
      repeat (200) @(negedge mclk);
      chk("idle_bad_code", 1'b1, strobes == s0);
      chk("valid_bad_code", 1'b0, code_valid);
      enable = 1'b0;
      @(negedge mclk);
    end
    $display("test bad codes done");
    run_code(1 + rnd % 32, 1026);
    $display("test full epoch done");
    code_num = 6'h05;
    enable = 1'b1;
    malfunction = 1'b1;
    for (i = 0; i < 20 && fallback_active !== 1'b1; i++) @(negedge mclk);
    chk("fallback_on", 1'b1, fallback_active);
    repeat (800) @(negedge mclk);
    enable = 1'b0;
    repeat (100) @(negedge mclk);
    chk("fallback_held", 1'b1, fallback_active);
    chk("fallback_differs", 1'b1, fb_diff > 0);
    malfunction = 1'b0;
    reset = 1'b1;
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    chk("fallback_cleared", 1'b0, fallback_active);
    $display("test fallback done");
    close_out();
  end
endmodule
